// ==== hdl/usd_defs.svh ====
`ifndef USD_DEFS_SVH
`define USD_DEFS_SVH

// Register byte offsets
`define USD_REG_CTRL    8'h00
`define USD_REG_STAT    8'h04
`define USD_REG_VPN     8'h08
`define USD_REG_OFFS    8'h0c

// Control register reset value and width
`define USD_CTRL_W      16
`define USD_CTRL_RST    16'h0000

// Privilege level field encodings
`define USD_PRIV_KERN   2'h0
`define USD_PRIV_SUP    2'h1
`define USD_PRIV_USER   2'h2

// Address bit positions
`define USD_A32_MSB     31
`define USD_A32_TOP3_LO 29
`define USD_ASEG_SUP32  3'h6
`define USD_XUSEG_LO    40
`define USD_REGION_HI   63
`define USD_REGION_LO   62
`define USD_REGION_XU   2'h0
`define USD_REGION_XS   2'h1
`define USD_REGION_CS   2'h3
`define USD_OFF4K_W     12
`define USD_OFF16M_W    24

`endif

// ==== hdl/usd_pkg.sv ====
package usd_pkg;

   typedef enum logic [1:0] {
      USD_MODE_KERN = 2'h0,
      USD_MODE_SUP  = 2'h1,
      USD_MODE_USER = 2'h3,
      USD_MODE_RSVD = 2'h2
   } usd_mode_t;

   typedef enum logic [2:0] {
      USD_SEG_NONE   = 3'h0,
      USD_SEG_USEG   = 3'h1,
      USD_SEG_XUSEG  = 3'h3,
      USD_SEG_SUSEG  = 3'h2,
      USD_SEG_SSEG   = 3'h6,
      USD_SEG_XSUSEG = 3'h7,
      USD_SEG_XSSEG  = 3'h5,
      USD_SEG_CSSEG  = 3'h4
   } usd_seg_t;

   typedef struct packed {
      logic [7:0] addr_space_tag;
      logic       page_16m;
      logic       kernel_wide_addr_enable;
      logic       supervisor_wide_addr_enable;
      logic       user_wide_addr_enable;
      logic       error_level_flag;
      logic       exception_level_flag;
      logic [1:0] privilege_level_field;
   } usd_ctrl_t;

   typedef struct packed {
      usd_mode_t   mode;
      usd_seg_t    seg;
      logic        wide;
      logic        addr_err;
      logic        mapped;
      logic [27:0] virtual_page_index;
      logic [23:0] offset;
      logic [7:0]  addr_space_tag;
   } usd_res_t;

endpackage : usd_pkg

// ==== hdl/usd_decoder.sv ====
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "usd_defs.svh"
// Behaviour
// [RL1] 32-bit 4K: 12-bit offset, 20-bit index
// [RL2] 32-bit 16M: 24-bit offset, 8-bit index
// [RL3] 64-bit 4K: 28-bit index
// [RL4] 64-bit 16M: 16-bit index
// [RL5] User mode: level 10, flags clear
// [RL6] User wide enable picks segment, handler
// [RL7] 32-bit User: bit 31 set errors
// [RL8] 64-bit User: bits 63:40 nonzero error
// [RL9] User segment always translated through TLB
// [RL10] 32-bit addresses must be sign-extended
// [RL11] Supervisor mode: level 01, flags clear
// [RL12] Supervisor wide enable picks segment, handler
// [RL13] 32-bit Supervisor: bit 31 clear, user segment
// [RL14] 32-bit Supervisor: top bits 110 segment
// [RL15] 64-bit Supervisor: region 00 user segment
// [RL16] 64-bit Supervisor: region 01 current segment
// [RL17] 64-bit Supervisor: region 11 separate segment
// [RL18] Mapped segments carry the space tag
// [RL19] Undecoded supervisor address raises error
// [RL20] Kernel mode overrides user and supervisor
// [RL21] Hit: index match, global or tag match
module usd_decoder #(
   parameter int VA_W  = 64,
   parameter int VPN_W = 28
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [7:0]       adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   output logic                  err_o,
   // Reference from address generation
   input  wire logic             req_valid_i,
   input  wire logic [VA_W-1:0]  req_addr_i,
   // Candidate TLB entry
   input  wire logic [VPN_W-1:0] entry_vpn_i,
   input  wire logic [7:0]       entry_tag_i,
   input  wire logic             entry_global_i,
   // Decode result
   output logic                  res_valid_o,
   output usd_pkg::usd_res_t     res_o,
   output logic                  tlb_hit_o,
   output logic                  tlb_miss_o,
   output logic                  wide_refill_handler_o
);

   usd_pkg::usd_ctrl_t ctrl;
   usd_pkg::usd_ctrl_t next_ctrl;
   logic               next_ack;
   logic               next_err;
   logic [31:0]        next_dat;
   usd_pkg::usd_res_t  next_res;
   logic               next_valid;
   logic               next_hit;
   logic               next_miss;
   logic               next_wref;

   // Register bus
   logic wb_req;
   logic wb_ctrl;
   logic wb_stat;
   logic wb_vpn;
   logic wb_offs;

   always_comb
   begin
      wb_req  = cyc_i && stb_i && !ack_o && !err_o;
      wb_ctrl = 1'b0;
      wb_stat = 1'b0;
      wb_vpn  = 1'b0;
      wb_offs = 1'b0;
      if (adr_i == `USD_REG_CTRL)
         wb_ctrl = 1'b1;
      else if (adr_i == `USD_REG_STAT)
         wb_stat = 1'b1;
      else if (adr_i == `USD_REG_VPN)
         wb_vpn = 1'b1;
      else if (adr_i == `USD_REG_OFFS)
         wb_offs = 1'b1;
   end

   always_comb
   begin
      next_ctrl = ctrl;
      next_dat  = dat_o;
      next_ack  = 1'b0;
      next_err  = 1'b0;
      if (wb_req)
      begin
         next_ack = wb_ctrl || wb_stat || wb_vpn || wb_offs;
         next_err = !next_ack;
         next_dat = 32'h0;
         if (wb_ctrl && we_i)
         begin
            if (sel_i[0])
               next_ctrl[7:0] = dat_i[7:0];
            if (sel_i[1])
               next_ctrl[15:8] = dat_i[15:8];
         end
         if (wb_ctrl)
            next_dat = {16'h0, ctrl};
         else if (wb_stat)
            next_dat = {22'h0, res_valid_o, tlb_hit_o, res_o.mapped,
                        res_o.addr_err, res_o.wide, res_o.seg, res_o.mode};
         else if (wb_vpn)
            next_dat = {4'h0, res_o.virtual_page_index};
         else if (wb_offs)
            next_dat = {res_o.addr_space_tag, res_o.offset};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl  <= usd_pkg::usd_ctrl_t'(`USD_CTRL_RST);
         dat_o <= 32'h0;
         ack_o <= 1'b0;
         err_o <= 1'b0;
      end
      else
      begin
         ctrl  <= next_ctrl;
         dat_o <= next_dat;
         ack_o <= next_ack;
         err_o <= next_err;
      end
   end

   // Address decode
   logic       kern;
   logic       sext_ok;
   logic [1:0] region;
   logic       upper_zero;
   logic       upper_ones;

   always_comb
   begin
      next_res   = '0;
      next_valid = req_valid_i;
      kern       = (ctrl.privilege_level_field == `USD_PRIV_KERN) ||
                   ctrl.exception_level_flag || ctrl.error_level_flag;
      // Any bit above 31 differing from bit 31 breaks sign extension
      sext_ok    = req_addr_i[VA_W-1:`USD_A32_MSB+1] ==
                   {(VA_W-`USD_A32_MSB-1){req_addr_i[`USD_A32_MSB]}};
      region     = req_addr_i[`USD_REGION_HI:`USD_REGION_LO];
      upper_zero = req_addr_i[`USD_REGION_LO-1:`USD_XUSEG_LO] == '0;
      upper_ones = &req_addr_i[`USD_REGION_LO-1:`USD_A32_MSB+1];
      next_res.seg = usd_pkg::USD_SEG_NONE;
      if (kern)
      begin
         // Kernel segments are decoded elsewhere
         next_res.mode = usd_pkg::USD_MODE_KERN; // RL20
         next_res.wide = ctrl.kernel_wide_addr_enable;
      end
      else if (ctrl.privilege_level_field == `USD_PRIV_USER)
      begin
         next_res.mode = usd_pkg::USD_MODE_USER; // RL5
         next_res.wide = ctrl.user_wide_addr_enable; // RL6
         if (!next_res.wide)
         begin
            next_res.seg      = usd_pkg::USD_SEG_USEG;
            next_res.addr_err = !sext_ok || req_addr_i[`USD_A32_MSB]; // RL7 RL10
         end
         else
         begin
            next_res.seg      = usd_pkg::USD_SEG_XUSEG;
            next_res.addr_err = req_addr_i[VA_W-1:`USD_XUSEG_LO] != '0; // RL8
         end
      end
      else if (ctrl.privilege_level_field == `USD_PRIV_SUP)
      begin
         next_res.mode = usd_pkg::USD_MODE_SUP; // RL11
         next_res.wide = ctrl.supervisor_wide_addr_enable; // RL12
         if (!next_res.wide)
         begin
            if (!sext_ok)
               next_res.seg = usd_pkg::USD_SEG_NONE; // RL10
            else if (!req_addr_i[`USD_A32_MSB])
               next_res.seg = usd_pkg::USD_SEG_SUSEG; // RL13
            else if (req_addr_i[`USD_A32_MSB:`USD_A32_TOP3_LO] == `USD_ASEG_SUP32)
               next_res.seg = usd_pkg::USD_SEG_SSEG; // RL14
         end
         else
         begin
            if (region == `USD_REGION_XU && upper_zero)
               next_res.seg = usd_pkg::USD_SEG_XSUSEG; // RL15
            else if (region == `USD_REGION_XS && upper_zero)
               next_res.seg = usd_pkg::USD_SEG_XSSEG; // RL16
            else if (region == `USD_REGION_CS && upper_ones &&
                     req_addr_i[`USD_A32_MSB:`USD_A32_TOP3_LO] == `USD_ASEG_SUP32)
               next_res.seg = usd_pkg::USD_SEG_CSSEG; // RL17
         end
         next_res.addr_err = next_res.seg == usd_pkg::USD_SEG_NONE; // RL19
      end
      else
      begin
         // Reserved level has no segments; refuse every reference
         next_res.mode     = usd_pkg::USD_MODE_RSVD;
         next_res.addr_err = 1'b1;
      end
      // User and supervisor segments are all mapped
      next_res.mapped = !next_res.addr_err &&
                        next_res.seg != usd_pkg::USD_SEG_NONE; // RL9
      if (next_res.wide)
      begin
         if (ctrl.page_16m)
            next_res.virtual_page_index =
               {12'h0, req_addr_i[`USD_XUSEG_LO-1:`USD_OFF16M_W]}; // RL4
         else
            next_res.virtual_page_index =
               req_addr_i[`USD_XUSEG_LO-1:`USD_OFF4K_W]; // RL3
      end
      else
      begin
         if (ctrl.page_16m)
            next_res.virtual_page_index =
               {20'h0, req_addr_i[`USD_A32_MSB:`USD_OFF16M_W]}; // RL2
         else
            next_res.virtual_page_index =
               {8'h0, req_addr_i[`USD_A32_MSB:`USD_OFF4K_W]}; // RL1
      end
      if (ctrl.page_16m)
         next_res.offset = req_addr_i[`USD_OFF16M_W-1:0]; // RL2
      else
         next_res.offset = {12'h0, req_addr_i[`USD_OFF4K_W-1:0]}; // RL1
      if (next_res.mapped)
         next_res.addr_space_tag = ctrl.addr_space_tag; // RL18
      next_hit  = req_valid_i && next_res.mapped &&
                  entry_vpn_i == next_res.virtual_page_index &&
                  (entry_global_i || entry_tag_i == next_res.addr_space_tag); // RL21
      next_miss = req_valid_i && next_res.mapped && !next_hit;
      next_wref = next_miss && next_res.wide; // RL6 RL12
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         res_valid_o           <= 1'b0;
         res_o                 <= '0;
         tlb_hit_o             <= 1'b0;
         tlb_miss_o            <= 1'b0;
         wide_refill_handler_o <= 1'b0;
      end
      else
      begin
         res_valid_o           <= next_valid;
         res_o                 <= next_res;
         tlb_hit_o             <= next_hit;
         tlb_miss_o            <= next_miss;
         wide_refill_handler_o <= next_wref;
      end
   end

   // Checks
   logic is_user;
   logic is_sup;

   assign is_user = ctrl.privilege_level_field == `USD_PRIV_USER &&
                    !ctrl.exception_level_flag && !ctrl.error_level_flag;
   assign is_sup  = ctrl.privilege_level_field == `USD_PRIV_SUP &&
                    !ctrl.exception_level_flag && !ctrl.error_level_flag;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_user_msb_err: assert property ( // RL7
      req_valid_i && is_user && !ctrl.user_wide_addr_enable &&
      req_addr_i[`USD_A32_MSB] |=> res_o.addr_err && !res_o.mapped)
      else $error("User narrow bit 31 not refused");

   chk_user_wide_err: assert property ( // RL8
      req_valid_i && is_user && ctrl.user_wide_addr_enable |=>
      res_o.addr_err == ($past(req_addr_i[VA_W-1:`USD_XUSEG_LO]) != '0))
      else $error("User wide upper bits check wrong");

   chk_narrow_sext: assert property ( // RL10
      req_valid_i && (is_user || is_sup) && !next_res.wide && !sext_ok
      |=> res_o.addr_err)
      else $error("Unextended narrow address accepted");

   chk_kernel_over: assert property ( // RL20
      req_valid_i && (ctrl.exception_level_flag || ctrl.error_level_flag)
      |=> res_o.mode == usd_pkg::USD_MODE_KERN && !res_o.addr_err)
      else $error("Kernel mode did not override");

   chk_sup_sseg: assert property ( // RL14
      req_valid_i && is_sup && !ctrl.supervisor_wide_addr_enable && sext_ok &&
      req_addr_i[`USD_A32_MSB:`USD_A32_TOP3_LO] == `USD_ASEG_SUP32
      |=> res_o.seg == usd_pkg::USD_SEG_SSEG && res_o.mapped)
      else $error("Supervisor segment not selected");

   chk_sup_xsseg: assert property ( // RL16
      req_valid_i && is_sup && ctrl.supervisor_wide_addr_enable &&
      region == `USD_REGION_XS && upper_zero |=> res_o.seg == usd_pkg::USD_SEG_XSSEG)
      else $error("Current supervisor segment not selected");

   chk_sup_err: assert property ( // RL19
      res_valid_o && res_o.mode == usd_pkg::USD_MODE_SUP |->
      res_o.addr_err == (res_o.seg == usd_pkg::USD_SEG_NONE))
      else $error("Supervisor error and segment disagree");

   chk_tag_attach: assert property ( // RL18
      req_valid_i && next_res.mapped |=>
      res_o.addr_space_tag == $past(ctrl.addr_space_tag))
      else $error("Space tag not attached");

   chk_vpn_4k: assert property ( // RL1
      req_valid_i && is_user && !ctrl.user_wide_addr_enable && !ctrl.page_16m
      |=> res_o.virtual_page_index[19:0] == $past(req_addr_i[31:12]) &&
          res_o.offset[11:0] == $past(req_addr_i[11:0]))
      else $error("Narrow 4K split wrong");

   chk_hit_miss: assert property ( // RL21
      res_valid_o |-> !(tlb_hit_o && tlb_miss_o) &&
      (tlb_hit_o || tlb_miss_o) == res_o.mapped)
      else $error("Hit and miss inconsistent");

   chk_wide_refill: assert property ( // RL6
      tlb_miss_o |-> wide_refill_handler_o == res_o.wide)
      else $error("Refill handler choice wrong");

   chk_wb_ack: assert property (
      cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o ##1 !ack_o && !err_o)
      else $error("Bus answer not one cycle");

   cov_user_hit: cover property (res_valid_o && tlb_hit_o &&
                                 res_o.mode == usd_pkg::USD_MODE_USER);
   cov_csseg: cover property (res_valid_o && res_o.seg == usd_pkg::USD_SEG_CSSEG);
   cov_wide_miss: cover property (wide_refill_handler_o);
   cov_bus_err: cover property (err_o);

endmodule : usd_decoder

// ==== test/usd_agen_model.sv ====
`timescale 1ns/100ps
module usd_agen_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Reference toward the decoder
   output logic             req_valid_o,
   output logic [63:0]      req_addr_o,
   output logic [27:0]      entry_vpn_o,
   output logic [7:0]       entry_tag_o,
   output logic             entry_global_o
);
   logic [100:0] pend_q[$];
   logic [100:0] head;

   task automatic push(input logic [100:0] ref_v);
      pend_q.push_back(ref_v);
   endtask : push

   initial
   begin
      req_valid_o = 1'b0;
      req_addr_o  = 64'h0;
      entry_vpn_o = 28'h0;
      entry_tag_o = 8'h0;
      entry_global_o = 1'b0;
   end

   // Idle address, index and tag lines toggle so a stale reference never looks live
   always @(posedge clk_i)
   begin
      if (rst_i || pend_q.size() == 0)
      begin
         req_valid_o <= 1'b0;
         req_addr_o  <= ~req_addr_o;
         entry_vpn_o <= ~entry_vpn_o;
         entry_tag_o <= ~entry_tag_o;
      end
      else
      begin
         head = pend_q.pop_front();
         {req_addr_o, entry_vpn_o, entry_tag_o, entry_global_o} <= head;
         req_valid_o <= 1'b1;
      end
   end
endmodule : usd_agen_model

// ==== test/user_supervisor_segment_decoder_tb.sv ====
`timescale 1ns/100ps
`include "usd_defs.svh"
module user_supervisor_segment_decoder_tb;
   logic               clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               cyc_i = 1'b0;
   logic               stb_i = 1'b0;
   logic               we_i  = 1'b0;
   logic [7:0]         adr_i = 8'h0;
   logic [3:0]         sel_i = 4'h0;
   logic [31:0]        dat_i = 32'h0;
   logic [31:0]        dat_o;
   logic               ack_o, err_o, res_valid_o, tlb_hit_o, tlb_miss_o, wrh_o;
   wire logic          req_valid, e_glb;
   wire logic [63:0]   req_addr;
   wire logic [27:0]   e_vpn;
   wire logic [7:0]    e_tag;
   usd_pkg::usd_res_t  res_o, er;
   usd_pkg::usd_res_t  exp_q[$];
   logic [2:0]         hm_q[$];
   logic [2:0]         eh;
   logic [15:0]        ctrl = 16'h0;
   integer             bad_count = 0;
   integer             comparisons = 0;
   integer             seed = 49;

   always #5 clk_i = ~clk_i;

   usd_agen_model agen_u (.clk_i(clk_i), .rst_i(rst_i), .req_valid_o(req_valid),
      .req_addr_o(req_addr), .entry_vpn_o(e_vpn), .entry_tag_o(e_tag), .entry_global_o(e_glb));

   usd_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .err_o(err_o), .req_valid_i(req_valid), .req_addr_i(req_addr), .entry_vpn_i(e_vpn),
      .entry_tag_i(e_tag), .entry_global_i(e_glb), .res_valid_o(res_valid_o), .res_o(res_o),
      .tlb_hit_o(tlb_hit_o), .tlb_miss_o(tlb_miss_o), .wide_refill_handler_o(wrh_o));

   task automatic end_sim;
      if (bad_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'h3;
      n = 0;
      // Answer and read data are taken at the edge that sees ack
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      q = dat_o;
      e = err_o;
      chk("bus_answer", n < 20, 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb

   // Prediction uses the control value the bench last wrote
   task automatic issue(input logic [63:0] a, input logic match, input logic [7:0] et,
                        input logic eg);
      usd_pkg::usd_res_t r;
      logic              k, hit;
      logic [27:0]       ev;
      r = '0;
      hit = 1'b0;
      ev = 28'($random(seed));
      k = ctrl[1:0] == 2'h0 || ctrl[2] || ctrl[3];
      if (!k && ctrl[1:0] == 2'h2)
      begin
         r.mode = usd_pkg::USD_MODE_USER;
         r.wide = ctrl[4];
         r.seg  = ctrl[4] ? usd_pkg::USD_SEG_XUSEG : usd_pkg::USD_SEG_USEG;
         r.addr_err = ctrl[4] ? a[63:40] != '0 : a[63:31] != '0;
      end
      else if (!k && ctrl[1:0] == 2'h1)
      begin
         r.mode = usd_pkg::USD_MODE_SUP;
         r.wide = ctrl[5];
         if (!ctrl[5] && a[63:32] == {32{a[31]}})
            r.seg = !a[31] ? usd_pkg::USD_SEG_SUSEG :
                    a[31:29] == 3'h6 ? usd_pkg::USD_SEG_SSEG : usd_pkg::USD_SEG_NONE;
         if (ctrl[5] && a[61:40] == '0)
            r.seg = a[63:62] == 2'h0 ? usd_pkg::USD_SEG_XSUSEG :
                    a[63:62] == 2'h1 ? usd_pkg::USD_SEG_XSSEG : usd_pkg::USD_SEG_NONE;
         if (ctrl[5] && a[63:29] == {32'hffffffff, 3'h6})
            r.seg = usd_pkg::USD_SEG_CSSEG;
         r.addr_err = r.seg == usd_pkg::USD_SEG_NONE;
      end
      else if (!k)
      begin
         r.mode     = usd_pkg::USD_MODE_RSVD;
         r.addr_err = 1'b1;
      end
      r.mapped = !r.addr_err && r.seg != usd_pkg::USD_SEG_NONE;
      if (r.mapped)
      begin
         r.virtual_page_index = ctrl[7] ? (r.wide ? a[39:24] : a[31:24])
                                        : (r.wide ? a[39:12] : a[31:12]);
         r.offset = ctrl[7] ? a[23:0] : a[11:0];
         r.addr_space_tag = ctrl[15:8];
         if (match) ev = r.virtual_page_index;
         hit = ev == r.virtual_page_index && (eg || et == ctrl[15:8]);
      end
      exp_q.push_back(r);
      hm_q.push_back({hit, r.mapped && !hit, r.wide});
      agen_u.push({a, ev, et, eg});
   endtask : issue

   always @(negedge clk_i)
   begin
      if (res_valid_o === 1'b1)
      begin
         chk("res_pending", exp_q.size() > 0, 1'b1);
         er = exp_q.pop_front();
         eh = hm_q.pop_front();
         chk("mode", res_o.mode, er.mode);
         chk("seg", res_o.seg, er.seg);
         chk("addr_err", res_o.addr_err, er.addr_err);
         chk("mapped", res_o.mapped, er.mapped);
         chk("hit", tlb_hit_o, eh[2]);
         chk("miss", tlb_miss_o, eh[1]);
         if (er.mode inside {usd_pkg::USD_MODE_SUP, usd_pkg::USD_MODE_USER})
            chk("wide", res_o.wide, er.wide);
         if (eh[1])
            chk("handler", wrh_o, eh[0]);
         if (er.mapped)
         begin
            chk("page_index", res_o.virtual_page_index, er.virtual_page_index);
            chk("offset", res_o.offset, er.offset);
            chk("tag", res_o.addr_space_tag, er.addr_space_tag);
         end
      end
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      end_sim;
   end

   initial
   begin : main_seq
      logic [31:0] q, q0, r;
      logic [63:0] a;
      logic        e;
      logic [5:0]  k;
      usd_pkg::usd_mode_t m;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `USD_REG_CTRL, 32'h0, q, e);
      chk("ctrl_reset", q[15:0], `USD_CTRL_RST);
      wb(1'b0, 8'h10, 32'h0, q, e);
      chk("unmapped_err", e, 1'b1);
      wb(1'b0, `USD_REG_OFFS, 32'h0, q0, e);
      wb(1'b1, `USD_REG_OFFS, 32'hffffffff, q, e);
      wb(1'b0, `USD_REG_OFFS, 32'h0, q, e);
      chk("offs_read_only", q, q0);
      for (int i = 0; i < 32; i++)
      begin
         r = $random(seed);
         ctrl = {r[15:8], i[3], r[6], i[2], i[2], i[4] & r[0], i[4] & ~r[0], i[1:0]};
         wb(1'b1, `USD_REG_CTRL, {16'h0, ctrl}, q, e);
         wb(1'b0, `USD_REG_CTRL, 32'h0, q, e);
         chk("ctrl_rw", q[15:0], ctrl);
         // Mode and idle status bits do not depend on the toggling idle address
         m = (ctrl[3:2] != 2'h0 || ctrl[1:0] == 2'h0) ? usd_pkg::USD_MODE_KERN :
             (ctrl[1:0] == 2'h2) ? usd_pkg::USD_MODE_USER :
             (ctrl[1:0] == 2'h1) ? usd_pkg::USD_MODE_SUP : usd_pkg::USD_MODE_RSVD;
         wb(1'b0, `USD_REG_STAT, 32'h0, q, e);
         chk("stat_mode", {q[9:8], q[1:0]}, {2'h0, m});
         repeat (12)
         begin
            a = {$random(seed), $random(seed)};
            k = 6'($random(seed));
            case (k[2:0])
               3'h0: a[63:32] = '0;
               3'h1: a[63:32] = '1;
               3'h2: a[63:40] = 24'h400000;
               3'h3: a[63:40] = '0;
               3'h4: a[63:29] = {32'hffffffff, 3'h6};
               default: ;
            endcase
            issue(a, k[3], k[4] ? ctrl[15:8] : 8'($random(seed)), k[5]);
         end
         // One result per cycle after a single cycle of latency
         repeat (16) @(posedge clk_i);
      end
      chk("drained", exp_q.size(), 0);
      end_sim;
   end
endmodule : user_supervisor_segment_decoder_tb
